// ### dv/srf_host.sv
`timescale 1ns/1ps
// Host end of the serial link: sends words on rxd and decodes the flow codes on txd.
module srf_host (
	input  wire logic                       clk,
	input  wire logic                       txd,
	input  wire logic [srf_pkg::CYC_W-1:0]  bit_cyc,
	input  wire logic                       par_en,
	input  wire logic                       par_odd,
	output logic                            rxd,
	output logic [7:0]                      code,
	output int                              code_cnt
);
	logic [7:0] d;

	initial begin
		rxd = 1'b1;
		code = 8'h00;
		code_cnt = 0;
	end

	////////////////////////////////////////////////////////////////////////////
	// The trailing mark bit returns the line to idle even after a bad stop bit.
	task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
		logic q[$];
		q = {1'b0};
		for (int i = 0; i < 8; i++) begin
			q.push_back(b[i]);
		end
		if (par_en) begin
			q.push_back(^b ^ par_odd ^ bad_par);
		end
		q.push_back(~bad_stop);
		q.push_back(1'b1);
		@(posedge clk);
		foreach (q[i]) begin
			rxd <= q[i];
			repeat (bit_cyc) @(posedge clk);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// The host only records each received flow code in code and counts it in code_cnt; it keeps sending after X-OFF, and the bench checks both.
	always begin
		@(negedge txd);
		repeat (bit_cyc / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_cyc) @(posedge clk);
			d[i] = txd;
		end
		if (par_en) begin
			repeat (bit_cyc) @(posedge clk);
		end
		repeat (bit_cyc) @(posedge clk);
		code = d;
		code_cnt++;
	end
endmodule

// ### dv/srf_top_tb_top.sv
`timescale 1ns/1ps
module srf_top_tb_top;
	logic                          clk;
	logic                          rst;
	logic [3:0]                    sw;
	logic                          rxd;
	logic                          txd;
	logic                          ready_busy_line;
	logic                          irq;
	logic [srf_pkg::ADDR_W-1:0]    avs_address;
	logic                          avs_read;
	logic                          avs_write;
	logic [31:0]                   avs_writedata;
	logic [31:0]                   avs_readdata;
	logic                          avs_waitrequest;
	logic [srf_pkg::CYC_W-1:0]     bc;
	logic [7:0]                    code;
	int                            code_cnt;
	int                            error_cnt;
	int                            cmp_count;
	int                            cyc;
	int                            n0;
	logic [31:0]                   v;

	assign bc = (sw == 4'h0) ? 17'h000a0 : 17'(160 >> ((sw - 4'h1) % 5));

	srf_top #(.BIT_CYC_1200(160), .BUF_DEPTH(512)) dut_u (
		.clk(clk), .rst(rst), .ce(1'b1), .option_switch_bank(sw), .rxd(rxd), .txd(txd),
		.ready_busy_line(ready_busy_line), .irq(irq), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
	);

	srf_host host_u (
		.clk(clk), .txd(txd), .bit_cyc(bc), .par_en(sw > 4'h5), .par_odd(sw inside {[4'h6:4'ha]}),
		.rxd(rxd), .code(code), .code_cnt(code_cnt)
	);

	always #5 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Each request starts one edge after the last release, so no signal is assigned twice in a step.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] junk;
		bus(1'b1, a, d, junk);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask

	task automatic wait_code(input int n);
		int k;
		k = 0;
		while (code_cnt < n && k < 5000) begin
			@(posedge clk);
			k++;
		end
		chk(32'(code_cnt), 32'(n));
	endtask

	task automatic tally_and_finish();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		sw = 4'h5;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		error_cnt = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({txd, ready_busy_line, irq, avs_waitrequest}, 4'b1101);
		wait_code(1);
		chk(code, srf_pkg::XON_CODE);
		rdc(srf_pkg::REG_CTRL, 32'h0);
		rdc(srf_pkg::REG_MASK, 32'h0);
		rdc(srf_pkg::REG_STATUS, 32'h20);
		rdc(srf_pkg::REG_STATUS, 32'h0);
		rdc(5'h14, 32'h0);
		rdc(srf_pkg::REG_DATA, 32'h0);
		chk(ready_busy_line, 1'b0);
		// Switch codes 1 to 15 once: good word, then a word with a flipped parity bit where parity is on.
		for (int s = 1; s < 16; s++) begin
			sw <= 4'(s);
			repeat (20) @(posedge clk);
			host_u.send(8'(s * 37), 1'b0, 1'b0);
			rdc(srf_pkg::REG_DATA, {23'h0, 1'b1, 8'(s * 37)});
			host_u.send(8'(s * 37), 1'b1, 1'b0);
			rdc(srf_pkg::REG_DATA, {23'h0, 1'b1, (s > 5) ? srf_pkg::QMARK : 8'(s * 37)});
		end
		rdc(srf_pkg::REG_STATUS, 32'h03);
		sw <= 4'h5;
		repeat (20) @(posedge clk);
		host_u.send(8'h5a, 1'b0, 1'b1);
		rdc(srf_pkg::REG_DATA, 32'h13f);
		rdc(srf_pkg::REG_STATUS, 32'h05);
		wr(srf_pkg::REG_MASK, 32'h2);
		host_u.send(8'h66, 1'b0, 1'b0);
		chk(irq, 1'b0);
		wr(srf_pkg::REG_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		rdc(srf_pkg::REG_STATUS, 32'h01);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		rdc(srf_pkg::REG_DATA, 32'h166);
		sw <= 4'h0;
		repeat (8) @(posedge clk);
		chk(ready_busy_line, 1'b1);
		host_u.send(8'h33, 1'b0, 1'b0);
		rdc(srf_pkg::REG_DATA, 32'h0);
		sw <= 4'h5;
		wr(srf_pkg::REG_CTRL, 32'h1);
		repeat (8) @(posedge clk);
		chk(ready_busy_line, 1'b0);
		wr(srf_pkg::REG_CTRL, 32'h3);
		repeat (3) @(posedge clk);
		chk(ready_busy_line, 1'b1);
		host_u.send(8'h44, 1'b0, 1'b0);
		rdc(srf_pkg::REG_DATA, 32'h13f);
		bus(1'b0, srf_pkg::REG_STATUS, 32'h0, v);
		chk(v & 32'h8, 32'h8);
		wr(srf_pkg::REG_CTRL, 32'h0);
		repeat (8) @(posedge clk);
		n0 = code_cnt;
		// Fill to the threshold, keep sending past X-OFF, then drain across it.
		for (int i = 0; i < 256; i++) begin
			host_u.send(8'(i), 1'b0, 1'b0);
		end
		wait_code(n0 + 1);
		chk(code, srf_pkg::XOFF_CODE);
		chk(ready_busy_line, 1'b1);
		rdc(srf_pkg::REG_LEVEL, 32'h30100);
		host_u.send(8'hee, 1'b0, 1'b0);
		rdc(srf_pkg::REG_LEVEL, 32'h30101);
		rdc(srf_pkg::REG_DATA, 32'h100);
		rdc(srf_pkg::REG_DATA, 32'h101);
		wait_code(n0 + 2);
		chk(code, srf_pkg::XON_CODE);
		rdc(srf_pkg::REG_LEVEL, 32'h000ff);
		for (int i = 2; i < 256; i++) begin
			rdc(srf_pkg::REG_DATA, 32'h100 | 32'(i));
		end
		rdc(srf_pkg::REG_DATA, 32'h1ee);
		rdc(srf_pkg::REG_DATA, 32'h0);
		chk(32'(code_cnt), 32'(n0 + 2));
		tally_and_finish();
	end
endmodule

// ### shared/srf_pkg.sv
package srf_pkg;
	localparam int CLK_HZ       = 100_000_000;
	localparam int BAUD_MIN     = 1200;
	localparam int BIT_CYC_1200 = CLK_HZ / BAUD_MIN;
	localparam int RATE_CNT     = 5;
	localparam int CYC_W        = 17;
	localparam int BUF_DEPTH    = 2048;
	localparam int XOFF_FREE    = 256;

	localparam logic [7:0] XON_CODE  = 8'h11;
	localparam logic [7:0] XOFF_CODE = 8'h13;
	localparam logic [7:0] QMARK     = 8'h3f;

	localparam logic [3:0] SW_PARALLEL  = 4'h0;
	localparam logic [3:0] SW_NONE_LO   = 4'h1;
	localparam logic [3:0] SW_ODD_LO    = 4'h6;
	localparam logic [3:0] SW_EVEN_LO   = 4'hb;

	localparam int          ADDR_W     = 5;
	localparam logic [4:0]  REG_CTRL   = 5'h00;
	localparam logic [4:0]  REG_STATUS = 5'h04;
	localparam logic [4:0]  REG_MASK   = 5'h08;
	localparam logic [4:0]  REG_DATA   = 5'h0c;
	localparam logic [4:0]  REG_LEVEL  = 5'h10;

	localparam int         CTRL_W    = 2;
	localparam int         CTRL_HW   = 0;
	localparam int         CTRL_HOLD = 1;
	localparam logic [1:0] CTRL_RST  = 2'h0;

	localparam int ST_W    = 6;
	localparam int ST_RX   = 0;
	localparam int ST_PAR  = 1;
	localparam int ST_FRM  = 2;
	localparam int ST_OVR  = 3;
	localparam int ST_XOFF = 4;
	localparam int ST_XON  = 5;

	localparam int DATA_VALID = 8;
	localparam int LVL_BUSY   = 16;
	localparam int LVL_XOFF   = 17;
endpackage

// ### src/srf_rx.sv
`timescale 1ns/1ps
module srf_rx (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     ce,
	input  wire logic                     rxd,
	input  wire logic [srf_pkg::CYC_W-1:0] bit_cyc,
	input  wire logic                     par_en,
	input  wire logic                     par_odd,
	output logic                          done,
	output logic [7:0]                    data,
	output logic                          perr,
	output logic                          ferr
);
	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100,
		RX_HOLD  = 3'b101
	} srf_rx_e;

	typedef struct packed {
		srf_rx_e                  st;
		logic [srf_pkg::CYC_W-1:0] cnt;
		logic [2:0]               nbit;
		logic [7:0]               sh;
		logic                     acc;
		logic                     pe;
		logic                     done;
		logic                     perr;
		logic                     ferr;
	} srf_rx_s;

	srf_rx_s q_q;
	srf_rx_s q_d;
	logic    tick;

	assign tick = (q_q.cnt == '0);

	always_comb begin
		q_d = q_q;
		q_d.done = 1'b0;
		if (!tick)
			q_d.cnt = q_q.cnt - 1'b1;
		unique case (q_q.st)
			RX_IDLE: begin
				// Start bit is a space after a mark idle; sample it mid-bit.
				if (!rxd) begin
					q_d.st = RX_START;
					q_d.cnt = bit_cyc >> 1;
				end
			end
			RX_START: begin
				if (tick) begin
					q_d.st = rxd ? RX_IDLE : RX_DATA;
					q_d.cnt = bit_cyc - 1'b1;
					q_d.nbit = 3'h0;
					q_d.acc = 1'b0;
					q_d.pe = 1'b0;
				end
			end
			RX_DATA: begin
				if (tick) begin
					q_d.sh = {rxd, q_q.sh[7:1]};
					q_d.acc = q_q.acc ^ rxd;
					q_d.cnt = bit_cyc - 1'b1;
					q_d.nbit = q_q.nbit + 1'b1;
					if (q_q.nbit == 3'h7)
						q_d.st = par_en ? RX_PAR : RX_STOP;
				end
			end
			RX_PAR: begin
				if (tick) begin
					q_d.pe = ((q_q.acc ^ rxd) != par_odd);
					q_d.cnt = bit_cyc - 1'b1;
					q_d.st = RX_STOP;
				end
			end
			RX_STOP: begin
				if (tick) begin
					q_d.done = 1'b1;
					q_d.ferr = !rxd;
					q_d.perr = par_en & q_q.pe;
					q_d.st = rxd ? RX_IDLE : RX_HOLD;
				end
			end
			RX_HOLD: begin
				// A line held at space must return to mark before a new word starts.
				if (rxd)
					q_d.st = RX_IDLE;
			end
			default: q_d.st = RX_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			q_q <= '0;
		else if (ce)
			q_q <= q_d;
	end

	assign done = q_q.done;
	assign data = q_q.sh;
	assign perr = q_q.perr;
	assign ferr = q_q.ferr;

	a_stop_space: assert property (@(posedge clk) disable iff (rst)
		(ce && q_q.st == RX_STOP && tick && !rxd) |=> (done && ferr))
		else $error("space at stop position did not flag framing");

	a_parity_off: assert property (@(posedge clk) disable iff (rst)
		(done && !par_en) |-> !perr)
		else $error("parity error flagged with parity off");
endmodule

// ### src/srf_top.sv
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module srf_top #(
	parameter int BIT_CYC_1200 = srf_pkg::BIT_CYC_1200,
	parameter int BUF_DEPTH    = srf_pkg::BUF_DEPTH
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      ce,
	input  wire logic [3:0]                option_switch_bank,
	input  wire logic                      rxd,
	output logic                           txd,
	output logic                           ready_busy_line,
	output logic                           irq,
	input  wire logic [srf_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	input  wire logic [3:0]                avs_byteenable,
	output logic [31:0]                    avs_readdata,
	output logic                           avs_waitrequest
);
	localparam int AW = $clog2(BUF_DEPTH);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(BUF_DEPTH);
	localparam logic [CW-1:0] THR_C   = CW'(srf_pkg::XOFF_FREE);

	if (BUF_DEPTH <= srf_pkg::XOFF_FREE || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0 ||
		(BIT_CYC_1200 >> 4) < 4 || BIT_CYC_1200 >= (1 << srf_pkg::CYC_W)) begin
		$error("srf_top: buffer depth or bit period out of range");
	end

	typedef struct packed {
		logic [3:0]                    sw_m;
		logic [3:0]                    sw_s;
		logic                          rx_m;
		logic                          rx_s;
		logic [srf_pkg::CTRL_W-1:0]    ctrl;
		logic [srf_pkg::ST_W-1:0]      st;
		logic [srf_pkg::ST_W-1:0]      mask;
		logic [BUF_DEPTH-1:0][7:0]     mem;
		logic [AW-1:0]                 wp;
		logic [AW-1:0]                 rp;
		logic [CW-1:0]                 cnt;
		logic                          busy;
		logic                          xoff_sent;
		logic                          tx_go;
		logic [7:0]                    tx_byte;
		logic                          waitreq;
		logic [31:0]                   rdata;
		logic                          irq;
	} srf_state_s;

	srf_state_s r_q;
	srf_state_s r_d;

	logic                      par_mode;
	logic                      par_en;
	logic                      par_odd;
	logic [2:0]                rate_idx;
	logic [srf_pkg::CYC_W-1:0] bit_cyc;
	logic [CW-1:0]             free;
	logic                      busy_cond;
	logic                      hw_mode;
	logic                      rx_done;
	logic [7:0]                rx_data;
	logic                      rx_perr;
	logic                      rx_ferr;
	logic                      tx_busy;
	logic                      full;
	logic                      push;
	logic                      push_ok;
	logic                      ovr;
	logic                      bad;
	logic [7:0]                push_byte;
	logic                      acc;
	logic                      pop;
	logic [srf_pkg::ST_W-1:0]  set;
	logic [srf_pkg::ST_W-1:0]  clr;

	////////////////////////////////////////////////////////////////////////////////
	// Option decode from the synchronised switch bank.

	always_comb begin
		par_mode = (r_q.sw_s == srf_pkg::SW_PARALLEL);
		par_en = (r_q.sw_s >= srf_pkg::SW_ODD_LO);
		par_odd = (r_q.sw_s < srf_pkg::SW_EVEN_LO);
		if (r_q.sw_s >= srf_pkg::SW_EVEN_LO)
			rate_idx = 3'(r_q.sw_s - srf_pkg::SW_EVEN_LO);
		else if (r_q.sw_s >= srf_pkg::SW_ODD_LO)
			rate_idx = 3'(r_q.sw_s - srf_pkg::SW_ODD_LO);
		else
			rate_idx = 3'(r_q.sw_s - srf_pkg::SW_NONE_LO);
		// Each step doubles the rate, so the period halves.
		bit_cyc = srf_pkg::CYC_W'(BIT_CYC_1200) >> rate_idx;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial engines.

	srf_rx u_rx (
		.clk     (clk),
		.rst     (rst),
		.ce      (ce),
		.rxd     (r_q.rx_s),
		.bit_cyc (bit_cyc),
		.par_en  (par_en),
		.par_odd (par_odd),
		.done    (rx_done),
		.data    (rx_data),
		.perr    (rx_perr),
		.ferr    (rx_ferr)
	);

	srf_tx u_tx (
		.clk     (clk),
		.rst     (rst),
		.ce      (ce),
		.go      (r_q.tx_go),
		.data    (r_q.tx_byte),
		.bit_cyc (bit_cyc),
		.par_en  (par_en),
		.par_odd (par_odd),
		.txd     (txd),
		.busy    (tx_busy)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Buffer, flow control and register file.

	always_comb begin
		hw_mode = r_q.ctrl[srf_pkg::CTRL_HW];
		free = DEPTH_C - r_q.cnt;
		full = (r_q.cnt == DEPTH_C);
		busy_cond = r_q.ctrl[srf_pkg::CTRL_HOLD] | par_mode | (free <= THR_C);
		push = rx_done && !par_mode;
		// Software mode tolerates words already in flight after X-OFF.
		ovr = (hw_mode && r_q.busy) || full;
		bad = rx_perr | rx_ferr | ovr;
		push_ok = push && !full;
		push_byte = bad ? srf_pkg::QMARK : rx_data;
		acc = (avs_read || avs_write) && r_q.waitreq;
		pop = acc && avs_read && (avs_address == srf_pkg::REG_DATA) && (r_q.cnt != '0);
		set = '0;
		set[srf_pkg::ST_RX] = push;
		set[srf_pkg::ST_PAR] = push & rx_perr;
		set[srf_pkg::ST_FRM] = push & rx_ferr;
		set[srf_pkg::ST_OVR] = push & ovr;
		set[srf_pkg::ST_XOFF] = r_q.tx_go & r_q.xoff_sent;
		set[srf_pkg::ST_XON] = r_q.tx_go & !r_q.xoff_sent;
		clr = (acc && avs_read && avs_address == srf_pkg::REG_STATUS) ? '1 : '0;
	end

	always_comb begin
		r_d = r_q;
		r_d.sw_m = option_switch_bank;
		r_d.sw_s = r_q.sw_m;
		r_d.rx_m = rxd;
		r_d.rx_s = r_q.rx_m;
		r_d.tx_go = 1'b0;
		r_d.busy = busy_cond;

		if (push_ok) begin
			r_d.mem[r_q.wp] = push_byte;
			r_d.wp = r_q.wp + 1'b1;
		end
		if (pop)
			r_d.rp = r_q.rp + 1'b1;
		unique case ({push_ok, pop})
			2'b10: r_d.cnt = r_q.cnt + 1'b1;
			2'b01: r_d.cnt = r_q.cnt - 1'b1;
			default: r_d.cnt = r_q.cnt;
		endcase

		// One code per change of the busy condition, software handshake and serial input only.
		if (!hw_mode && !par_mode && !tx_busy && !r_q.tx_go && busy_cond != r_q.xoff_sent) begin
			r_d.tx_go = 1'b1;
			r_d.tx_byte = busy_cond ? srf_pkg::XOFF_CODE : srf_pkg::XON_CODE;
			r_d.xoff_sent = busy_cond;
		end

		// A new event wins over a clear from the same read.
		r_d.st = (r_q.st & ~clr) | set;
		r_d.irq = |(r_d.st & r_q.mask);

		r_d.waitreq = 1'b1;
		if (acc) begin
			r_d.waitreq = 1'b0;
			r_d.rdata = '0;
			unique case (avs_address)
				srf_pkg::REG_CTRL: begin
					r_d.rdata[srf_pkg::CTRL_W-1:0] = r_q.ctrl;
					if (avs_write && avs_byteenable[0])
						r_d.ctrl = avs_writedata[srf_pkg::CTRL_W-1:0];
				end
				srf_pkg::REG_STATUS: r_d.rdata[srf_pkg::ST_W-1:0] = r_q.st;
				srf_pkg::REG_MASK: begin
					r_d.rdata[srf_pkg::ST_W-1:0] = r_q.mask;
					if (avs_write && avs_byteenable[0])
						r_d.mask = avs_writedata[srf_pkg::ST_W-1:0];
				end
				srf_pkg::REG_DATA: begin
					r_d.rdata[7:0] = r_q.mem[r_q.rp];
					r_d.rdata[srf_pkg::DATA_VALID] = (r_q.cnt != '0);
				end
				srf_pkg::REG_LEVEL: begin
					r_d.rdata[CW-1:0] = r_q.cnt;
					r_d.rdata[srf_pkg::LVL_BUSY] = r_q.busy;
					r_d.rdata[srf_pkg::LVL_XOFF] = r_q.xoff_sent;
				end
				default: r_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r_q <= '0;
			r_q.sw_m <= 4'h0;
			r_q.rx_m <= 1'b1;
			r_q.rx_s <= 1'b1;
			r_q.ctrl <= srf_pkg::CTRL_RST;
			r_q.busy <= 1'b1;
			r_q.xoff_sent <= 1'b1;
			r_q.waitreq <= 1'b1;
		end else if (ce) begin
			r_q <= r_d;
		end
	end

	assign ready_busy_line = r_q.busy;
	assign irq = r_q.irq;
	assign avs_readdata = r_q.rdata;
	assign avs_waitrequest = r_q.waitreq;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	a_busy_thresh: assert property (@(posedge clk) disable iff (rst)
		(ce && free <= THR_C) |=> ready_busy_line)
		else $error("ready line not busy with little free space");

	a_code_value: assert property (@(posedge clk) disable iff (rst)
		r_q.tx_go |-> (r_q.tx_byte == (r_q.busy ? srf_pkg::XOFF_CODE : srf_pkg::XON_CODE)))
		else $error("flow code does not match buffer state");

	a_overrun_flag: assert property (@(posedge clk) disable iff (rst)
		(ce && push && hw_mode && r_q.busy) |=> r_q.st[srf_pkg::ST_OVR])
		else $error("word during busy not flagged as overrun");

	a_qmark_store: assert property (@(posedge clk) disable iff (rst)
		(ce && push_ok && (rx_perr || rx_ferr)) |=> (r_q.mem[$past(r_q.wp)] == srf_pkg::QMARK))
		else $error("bad word not stored as question mark");

	a_hw_silent: assert property (@(posedge clk) disable iff (rst)
		(ce && hw_mode) |=> !r_q.tx_go)
		else $error("flow code sent in hardware handshake");

	a_wait_one: assert property (@(posedge clk) disable iff (rst)
		(ce && (avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");

	a_irq_raise: assert property (@(posedge clk) disable iff (rst)
		(ce && ((r_d.st & r_q.mask) != '0))
		|=> irq)
		else $error("interrupt low with an unmasked status bit set");

	a_irq_drop: assert property (@(posedge clk) disable iff (rst)
		(ce && ((r_d.st & r_q.mask) == '0))
		|=> !irq)
		else $error("interrupt high with no unmasked status bit");

	a_code_single: assert property (@(posedge clk) disable iff (rst)
		(ce && r_q.tx_go)
		|=> !r_q.tx_go)
		else $error("flow code launched twice in a row");

	a_code_start: assert property (@(posedge clk) disable iff (rst)
		(ce && r_q.tx_go)
		|=> tx_busy)
		else $error("flow code launch not taken by the transmitter");

	a_par_silent: assert property (@(posedge clk) disable iff (rst)
		(ce && par_mode)
		|=> !r_q.tx_go)
		else $error("flow code sent with parallel input selected");

	a_par_ignore: assert property (@(posedge clk) disable iff (rst)
		(ce && par_mode)
		|=> (r_q.wp == $past(r_q.wp)))
		else $error("serial word stored with parallel input selected");

	a_par_busy: assert property (@(posedge clk) disable iff (rst)
		(ce && par_mode)
		|=> ready_busy_line)
		else $error("ready line not busy with parallel input selected");

	a_hold_busy: assert property (@(posedge clk) disable iff (rst)
		(ce && r_q.ctrl[srf_pkg::CTRL_HOLD])
		|=> ready_busy_line)
		else $error("ready line not busy while held");

	a_ready_free: assert property (@(posedge clk) disable iff (rst)
		(ce && !r_q.ctrl[srf_pkg::CTRL_HOLD] && !par_mode && (free > THR_C))
		|=> !ready_busy_line)
		else $error("ready line busy with room and no hold");

	a_full_drop: assert property (@(posedge clk) disable iff (rst)
		(ce && push && full)
		|=> ((r_q.wp == $past(r_q.wp)) && r_q.st[srf_pkg::ST_OVR]))
		else $error("word into full buffer not dropped as overrun");

	a_level_max: assert property (@(posedge clk) disable iff (rst)
		ce
		|-> (r_q.cnt <= DEPTH_C))
		else $error("buffer level above depth");

	a_good_store: assert property (@(posedge clk) disable iff (rst)
		(ce && push_ok && !bad)
		|=> (r_q.mem[$past(r_q.wp)] == $past(rx_data)))
		else $error("good word not stored as received");

	a_ovr_qmark: assert property (@(posedge clk) disable iff (rst)
		(ce && push_ok && ovr)
		|=> (r_q.mem[$past(r_q.wp)] == srf_pkg::QMARK))
		else $error("overrun word not stored as question mark");

	a_pop_level: assert property (@(posedge clk) disable iff (rst)
		(ce && pop && !push_ok)
		|=> (r_q.cnt == $past(r_q.cnt) - 1'b1))
		else $error("buffer level not lowered by a data read");
endmodule

// ### src/srf_tx.sv
`timescale 1ns/1ps
module srf_tx (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     ce,
	input  wire logic                     go,
	input  wire logic [7:0]               data,
	input  wire logic [srf_pkg::CYC_W-1:0] bit_cyc,
	input  wire logic                     par_en,
	input  wire logic                     par_odd,
	output logic                          txd,
	output logic                          busy
);
	typedef struct packed {
		logic                     act;
		logic [srf_pkg::CYC_W-1:0] cnt;
		logic [3:0]               nleft;
		logic [9:0]               sh;
		logic                     txd;
	} srf_tx_s;

	srf_tx_s q_q;
	srf_tx_s q_d;

	always_comb begin
		q_d = q_q;
		if (q_q.cnt != '0)
			q_d.cnt = q_q.cnt - 1'b1;
		if (!q_q.act) begin
			if (go) begin
				// Same framing as the receive path: start, eight bits, parity, stop.
				q_d.act = 1'b1;
				q_d.txd = 1'b0;
				q_d.sh = {1'b1, par_en ? (^data ^ par_odd) : 1'b1, data};
				q_d.nleft = par_en ? 4'ha : 4'h9;
				q_d.cnt = bit_cyc - 1'b1;
			end
		end else if (q_q.cnt == '0) begin
			if (q_q.nleft == 4'h0) begin
				q_d.act = 1'b0;
			end else begin
				q_d.txd = q_q.sh[0];
				q_d.sh = {1'b1, q_q.sh[9:1]};
				q_d.nleft = q_q.nleft - 1'b1;
				q_d.cnt = bit_cyc - 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			q_q <= '{act: 1'b0, cnt: '0, nleft: 4'h0, sh: '1, txd: 1'b1};
		else if (ce)
			q_q <= q_d;
	end

	assign txd = q_q.txd;
	assign busy = q_q.act;

	a_start_space: assert property (@(posedge clk) disable iff (rst)
		(ce && go && !busy) |=> (!txd && busy))
		else $error("transmit did not open with a space start bit");
endmodule
